// ### rtl/flash_host_params.svh
// Summary of operation
// - Host reads with select and output enable low, write enable and reset high.
// - Host holds reset low at least 100ns for every reset.
// - Host waits reset-to-output-valid time before trusting its first read.
// - Host waits reset-to-write time after reset release before writing commands.
// - Flash reset pin follows the same system reset as the processor.
// - Command 90H enters configuration read, command FFH returns to read array.
// - One-time programming is command C0H, then data written at its address.
// - Customer area lock is C0H then FFFDH written to address 80H.
// - Commands written with select and write enable low, latched on first rising edge.
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// ************************************************************
// Register offsets and fields
// ************************************************************
`define FH_REG_CTRL 8'h00
`define FH_REG_ADDR 8'h04
`define FH_REG_WDATA 8'h08
`define FH_REG_RDATA 8'h0c
`define FH_REG_STATUS 8'h10
`define FH_CTRL_OP_LSB 0
`define FH_CTRL_BYTE_BIT 4
`define FH_CTRL_WP_BIT 5
`define FH_STAT_BUSY_BIT 0
`define FH_STAT_RDY_BIT 1
`define FH_STAT_DONE_BIT 2

// ************************************************************
// Flash commands and fixed locations
// ************************************************************
`define FH_CMD_ID_READ 16'h0090
`define FH_CMD_READ_ARRAY 16'h00ff
`define FH_CMD_OTP_PROG 16'h00c0
`define FH_LOCK_ADDR 21'h000080
`define FH_LOCK_DATA 16'hfffd

// ************************************************************
// Timing
// ************************************************************
`define FH_CLK_NS 10
`define FH_RESET_LOW_NS 100
`define FH_RESET_TO_OUT_NS 200
`define FH_RESET_TO_WRITE_NS 200
`define FH_READ_ACC_NS 90
`define FH_WE_LOW_NS 50
`define FH_CYC_UP(ns) (((ns) + `FH_CLK_NS - 1) / `FH_CLK_NS)

`endif

// ### rtl/flash_host_pkg.sv
package flash_host_pkg;

  // Operations that software can start
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_READ = 3'b001,
    OP_WRITE = 3'b010,
    OP_RESET = 3'b011,
    OP_ID_MODE = 3'b100,
    OP_ARRAY_MODE = 3'b101,
    OP_OTP_PROG = 3'b110,
    OP_OTP_LOCK = 3'b111
  } op_t;

  // Pin sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WR_LOW = 3'b010,
    ST_WR_HOLD = 3'b011,
    ST_RST_LOW = 3'b100,
    ST_RST_WAIT = 3'b101,
    ST_WR_GAP = 3'b110
  } state_t;

endpackage : flash_host_pkg

// ### rtl/flash_host.sv
`timescale 1ns/1ps
`include "flash_host_params.svh"

module flash_host #(
  parameter int RESET_LOW_CYC = `FH_CYC_UP(`FH_RESET_LOW_NS),
  parameter int RESET_OUT_CYC = `FH_CYC_UP(`FH_RESET_TO_OUT_NS),
  parameter int RESET_WR_CYC = `FH_CYC_UP(`FH_RESET_TO_WRITE_NS),
  parameter int READ_CYC = `FH_CYC_UP(`FH_READ_ACC_NS),
  parameter int WE_LOW_CYC = `FH_CYC_UP(`FH_WE_LOW_NS)
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Flash pins
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic reset_powerdown_n_out,
  output logic byte_mode_n_out,
  output logic write_protect_n_out,
  output logic [20:0] flash_addr_out,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe_out,
  input wire logic ready_busy_n_in
);

  // ************************************************************
  // Checks and derived counts
  // ************************************************************
  localparam int RST_WAIT_CYC = (RESET_OUT_CYC > RESET_WR_CYC) ? RESET_OUT_CYC : RESET_WR_CYC;

  if (RESET_LOW_CYC < 1 || RST_WAIT_CYC < 1 || READ_CYC < 1 || WE_LOW_CYC < 1 ||
      RESET_LOW_CYC > 65535 || RST_WAIT_CYC > 65535 || READ_CYC > 65535 || WE_LOW_CYC > 65535) begin : g_chk
    $error("flash_host: cycle counts must lie in 1..65535");
  end

  // ************************************************************
  // Register file
  // ************************************************************
  flash_host_pkg::state_t state_q;
  flash_host_pkg::op_t op_q;
  flash_host_pkg::op_t wr_op;
  logic [15:0] cnt_q, wdata_q, rdata_q;
  logic [20:0] addr_q;
  logic [36:0] word_first, word_second;
  logic second_q, byte_mode_q, wp_high_q, done_q, done_set, apb_wr, start, addr_ok;

  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign wr_op = flash_host_pkg::op_t'(pwdata_in[`FH_CTRL_OP_LSB +: 3]);
  // Starts while busy are dropped; software polls the busy bit first
  assign start = apb_wr && (paddr_in == `FH_REG_CTRL) && (wr_op != flash_host_pkg::OP_NONE) &&
                 (state_q == flash_host_pkg::ST_IDLE);
  assign addr_ok = (paddr_in == `FH_REG_CTRL) || (paddr_in == `FH_REG_ADDR) || (paddr_in == `FH_REG_WDATA) ||
                   (paddr_in == `FH_REG_RDATA) || (paddr_in == `FH_REG_STATUS);
  assign pready_out = 1'b1; // Zero wait states
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  // Configuration and operand registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      byte_mode_q <= 1'b0;
      wp_high_q <= 1'b0;
      addr_q <= 21'h000000;
      wdata_q <= 16'h0000;
    end else if (apb_wr) begin
      if (paddr_in == `FH_REG_CTRL) begin
        byte_mode_q <= pwdata_in[`FH_CTRL_BYTE_BIT];
        wp_high_q <= pwdata_in[`FH_CTRL_WP_BIT];
      end
      if (paddr_in == `FH_REG_ADDR) begin
        addr_q <= pwdata_in[20:0];
      end
      if (paddr_in == `FH_REG_WDATA) begin
        wdata_q <= pwdata_in[15:0];
      end
    end
  end

  // Sticky done flag; a completion in the clearing cycle wins
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (apb_wr && paddr_in == `FH_REG_STATUS && pwdata_in[`FH_STAT_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // Read data mux, zero for unmapped
  always_comb begin
    prdata_out = 32'h00000000;
    unique case (paddr_in)
      `FH_REG_CTRL: begin
        prdata_out[`FH_CTRL_BYTE_BIT] = byte_mode_q;
        prdata_out[`FH_CTRL_WP_BIT] = wp_high_q;
      end
      `FH_REG_ADDR: prdata_out[20:0] = addr_q;
      `FH_REG_WDATA: prdata_out[15:0] = wdata_q;
      `FH_REG_RDATA: prdata_out[15:0] = rdata_q;
      `FH_REG_STATUS: begin
        prdata_out[`FH_STAT_BUSY_BIT] = (state_q != flash_host_pkg::ST_IDLE);
        prdata_out[`FH_STAT_RDY_BIT] = ready_busy_n_in;
        prdata_out[`FH_STAT_DONE_BIT] = done_q;
      end
      default: prdata_out = 32'h00000000;
    endcase
  end

  assign byte_mode_n_out = !byte_mode_q;
  assign write_protect_n_out = wp_high_q;

  // ************************************************************
  // Pin sequencer
  // ************************************************************
  // Command word and address of each write phase
  function automatic logic [36:0] wr_word(input flash_host_pkg::op_t op, input logic second,
                                          input logic [20:0] a, input logic [15:0] d);
    logic [36:0] r;
    unique case (op)
      flash_host_pkg::OP_ID_MODE: r = {a, `FH_CMD_ID_READ};
      flash_host_pkg::OP_ARRAY_MODE: r = {a, `FH_CMD_READ_ARRAY};
      flash_host_pkg::OP_OTP_PROG: r = second ? {a, d} : {a, `FH_CMD_OTP_PROG};
      flash_host_pkg::OP_OTP_LOCK: r = second ? {`FH_LOCK_ADDR, `FH_LOCK_DATA} : {a, `FH_CMD_OTP_PROG};
      default: r = {a, d};
    endcase
    return r;
  endfunction : wr_word

  // Opening phase follows the new op, the second phase the latched one
  assign word_first = wr_word(wr_op, 1'b0, addr_q, wdata_q);
  assign word_second = wr_word(op_q, 1'b1, addr_q, wdata_q);
  assign done_set = ((state_q == flash_host_pkg::ST_READ) && (cnt_q == 16'h0001)) ||
                    ((state_q == flash_host_pkg::ST_WR_HOLD) &&
                     !((op_q == flash_host_pkg::OP_OTP_PROG || op_q == flash_host_pkg::OP_OTP_LOCK) && !second_q)) ||
                    ((state_q == flash_host_pkg::ST_RST_WAIT) && (cnt_q == 16'h0001));

  // Starts in reset so the flash is reset with the system
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= flash_host_pkg::ST_RST_LOW;
      op_q <= flash_host_pkg::OP_NONE;
      cnt_q <= 16'h0000;
      second_q <= 1'b0;
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      reset_powerdown_n_out <= 1'b0;
      flash_addr_out <= 21'h000000;
      dq_out <= 16'h0000;
      dq_oe_out <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      unique case (state_q)
        flash_host_pkg::ST_IDLE: begin
          if (start) begin
            op_q <= wr_op;
            second_q <= 1'b0;
            flash_addr_out <= word_first[36:16];
            if (wr_op == flash_host_pkg::OP_READ) begin
              ce_n_out <= 1'b0;
              oe_n_out <= 1'b0;
              cnt_q <= 16'(READ_CYC);
              state_q <= flash_host_pkg::ST_READ;
            end else if (wr_op == flash_host_pkg::OP_RESET) begin
              reset_powerdown_n_out <= 1'b0;
              cnt_q <= 16'h0000;
              state_q <= flash_host_pkg::ST_RST_LOW;
            end else begin
              ce_n_out <= 1'b0;
              we_n_out <= 1'b0;
              dq_oe_out <= 1'b1;
              dq_out <= word_first[15:0];
              cnt_q <= 16'(WE_LOW_CYC);
              state_q <= flash_host_pkg::ST_WR_LOW;
            end
          end
        end
        flash_host_pkg::ST_READ: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            rdata_q <= dq_in;
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            state_q <= flash_host_pkg::ST_IDLE;
          end
        end
        flash_host_pkg::ST_WR_LOW: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            we_n_out <= 1'b1;
            state_q <= flash_host_pkg::ST_WR_HOLD;
          end
        end
        flash_host_pkg::ST_WR_HOLD: begin
          // Address and data held a cycle past the rising write enable
          ce_n_out <= 1'b1;
          dq_oe_out <= 1'b0;
          if ((op_q == flash_host_pkg::OP_OTP_PROG || op_q == flash_host_pkg::OP_OTP_LOCK) && !second_q) begin
            second_q <= 1'b1;
            state_q <= flash_host_pkg::ST_WR_GAP;
          end else begin
            state_q <= flash_host_pkg::ST_IDLE;
          end
        end
        flash_host_pkg::ST_WR_GAP: begin
          flash_addr_out <= word_second[36:16];
          dq_out <= word_second[15:0];
          ce_n_out <= 1'b0;
          we_n_out <= 1'b0;
          dq_oe_out <= 1'b1;
          cnt_q <= 16'(WE_LOW_CYC);
          state_q <= flash_host_pkg::ST_WR_LOW;
        end
        flash_host_pkg::ST_RST_LOW: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q >= 16'(RESET_LOW_CYC - 1)) begin
            reset_powerdown_n_out <= 1'b1;
            cnt_q <= 16'(RST_WAIT_CYC);
            state_q <= flash_host_pkg::ST_RST_WAIT;
          end
        end
        flash_host_pkg::ST_RST_WAIT: begin
          // Covers both recovery times, so no access can start early
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            state_q <= flash_host_pkg::ST_IDLE;
          end
        end
        default: state_q <= flash_host_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // Helper counters: reset low length and time since release
  logic [15:0] low_len_q, since_rel_q;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_len_q <= 16'h0000;
      since_rel_q <= 16'h0000;
    end else begin
      low_len_q <= reset_powerdown_n_out ? 16'h0000 : low_len_q + 16'h0001;
      since_rel_q <= !reset_powerdown_n_out ? 16'h0000 :
                     (since_rel_q == 16'hffff) ? since_rel_q : since_rel_q + 16'h0001;
    end
  end

  sequence s_cmd_c0;
    $fell(we_n_out) && dq_out == `FH_CMD_OTP_PROG;
  endsequence
  sequence s_lock_data;
    $fell(we_n_out) && flash_addr_out == `FH_LOCK_ADDR && dq_out == `FH_LOCK_DATA;
  endsequence

  property p_read_pins;
    @(posedge clock_in) disable iff (!rst_n_in) !oe_n_out |-> (!ce_n_out && we_n_out && reset_powerdown_n_out);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("read without proper pin levels");
  property p_no_we_oe;
    @(posedge clock_in) disable iff (!rst_n_in) !(!we_n_out && !oe_n_out) && !(dq_oe_out && !oe_n_out);
  endproperty
  a_no_we_oe: assert property (p_no_we_oe) else $error("write and output enable overlap");
  property p_rst_min;
    @(posedge clock_in) disable iff (!rst_n_in) $rose(reset_powerdown_n_out) |-> low_len_q >= 16'(RESET_LOW_CYC);
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("reset pulse too short");
  property p_read_after_rst;
    @(posedge clock_in) disable iff (!rst_n_in) $fell(oe_n_out) |-> since_rel_q >= 16'(RESET_OUT_CYC);
  endproperty
  a_read_after_rst: assert property (p_read_after_rst) else $error("read too soon after reset");
  property p_wr_after_rst;
    @(posedge clock_in) disable iff (!rst_n_in) $fell(we_n_out) |-> since_rel_q >= 16'(RESET_WR_CYC);
  endproperty
  a_wr_after_rst: assert property (p_wr_after_rst) else $error("write too soon after reset");
  property p_we_edge_hold;
    @(posedge clock_in) disable iff (!rst_n_in)
      $rose(we_n_out) |-> !ce_n_out && dq_oe_out && $stable(dq_out) && $stable(flash_addr_out);
  endproperty
  a_we_edge_hold: assert property (p_we_edge_hold) else $error("write data not held at latch edge");
  property p_id_cmd;
    @(posedge clock_in) disable iff (!rst_n_in)
      $fell(we_n_out) && op_q == flash_host_pkg::OP_ID_MODE |-> dq_out == `FH_CMD_ID_READ;
  endproperty
  a_id_cmd: assert property (p_id_cmd) else $error("wrong identifier mode command");
  property p_otp_second;
    @(posedge clock_in) disable iff (!rst_n_in)
      $fell(we_n_out) && op_q == flash_host_pkg::OP_OTP_LOCK && second_q |-> s_lock_data;
  endproperty
  a_otp_second: assert property (p_otp_second) else $error("lock write does not follow C0 correctly");
  property p_otp_first;
    @(posedge clock_in) disable iff (!rst_n_in)
      $fell(we_n_out) && op_q inside {flash_host_pkg::OP_OTP_PROG, flash_host_pkg::OP_OTP_LOCK} &&
      !second_q |-> s_cmd_c0;
  endproperty
  a_otp_first: assert property (p_otp_first) else $error("program without C0 first");

endmodule : flash_host

// ### testbench/flash_dev_model.sv
`timescale 1ns/1ps

// ************************************************************
// Behavioural flash part seen from its pins
// ************************************************************
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0c3c, // Arbitrary value
  parameter logic [20:0] FACTORY_LAST = 21'h000084,
  parameter int ACC_NS = 70,
  parameter int RESET_MIN_NS = 100,
  parameter int WAKE_NS = 200
) (
  // Control pins
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic rp_n_in,
  input wire logic [20:0] addr_in,
  // Data pins
  input wire logic [15:0] dq_in,
  input wire logic dq_oe_in,
  output logic [15:0] dq_out,
  output logic ready_busy_n_out,
  output int viol_out
);
  logic id_mode_q, otp_next_q;
  logic [15:0] otp_q [0:15];
  logic [15:0] last_q, word_q;
  logic [7:0] status_q;
  realtime rp_rise, rp_fall;
  wire rd_en = !ce_n_in && !oe_n_in && rp_n_in;
  // No embedded operations run, so the pin reads ready
  assign ready_busy_n_out = 1'b1;
  // Floating bus shows inverted last word, never a stale copy
  assign #(ACC_NS) dq_out = rd_en ? word_q : ~last_q;
  initial begin
    viol_out = 0;
    rp_rise = 0;
    rp_fall = 0;
    for (int i = 0; i < 16; i++) otp_q[i] = 16'hffff;
    otp_q[0] = 16'hfffe;
  end
  // Reset returns to read array
  always @(negedge rp_n_in) begin
    rp_fall = $realtime;
    id_mode_q = 1'b0;
    otp_next_q = 1'b0;
    status_q = 8'h80;
  end
  // Minimum reset width, measured from the falling edge
  always @(posedge rp_n_in) begin
    if ($realtime - rp_fall < RESET_MIN_NS) viol_out++;
    rp_rise = $realtime;
  end
  always @(posedge oe_n_in) last_q = dq_out;
  // Word picked a little after select, once address has settled
  always @(negedge oe_n_in or negedge ce_n_in) begin
    #1;
    if (rd_en && $realtime - rp_rise < WAKE_NS) viol_out++;
    if (rd_en && !we_n_in) viol_out++;
    if (!id_mode_q) word_q = addr_in[15:0] ^ 16'h5a5a;
    else if (addr_in == 21'h0) word_q = MAKER_CODE;
    else if (addr_in == 21'h1) word_q = DEVICE_CODE;
    else if (addr_in[20:4] == 17'h8) word_q = otp_q[addr_in[3:0]];
    else if (addr_in == 21'h3 || addr_in[11:0] == 12'h002) word_q = 16'h0000;
    else word_q = 16'hffff;
  end
  // Latch on whichever strobe rises first
  always @(posedge we_n_in or posedge ce_n_in) begin
    if (rp_n_in && we_n_in != ce_n_in) begin
      if (!dq_oe_in || $realtime - rp_rise < WAKE_NS) viol_out++;
      if (otp_next_q) begin
        otp_next_q = 1'b0;
        if (addr_in[20:4] != 17'h8 || !otp_q[0][1] || (addr_in != 21'h80 && addr_in <= FACTORY_LAST))
          status_q = status_q | 8'h12;
        else otp_q[addr_in[3:0]] = otp_q[addr_in[3:0]] & dq_in;
      end else if (dq_in[7:0] == 8'h90) id_mode_q = 1'b1;
      else if (dq_in[7:0] == 8'hff) id_mode_q = 1'b0;
      else if (dq_in[7:0] == 8'hc0) otp_next_q = 1'b1;
    end
  end
endmodule : flash_dev_model

// ### testbench/flash_host_tb.sv
`timescale 1ns/1ps
`include "flash_host_params.svh"

module flash_host_tb;
  localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value
  localparam logic [15:0] DEVICE = 16'h0c3c; // Arbitrary value
  logic clock_in, rst_n_in, psel, penable, pwrite, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_out, rdv;
  logic pready_out, pslverr_out, ce_n_out, oe_n_out, we_n_out, rp_n, byte_n, wp_n, dq_oe, rb_n;
  logic [20:0] flash_addr;
  logic [15:0] dq_host, dq_dev;
  int mismatches, tests_run, viol;

  flash_host u_flash_host (.clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .ce_n_out(ce_n_out), .oe_n_out(oe_n_out),
    .we_n_out(we_n_out), .reset_powerdown_n_out(rp_n), .byte_mode_n_out(byte_n),
    .write_protect_n_out(wp_n), .flash_addr_out(flash_addr), .dq_in(dq_dev), .dq_out(dq_host),
    .dq_oe_out(dq_oe), .ready_busy_n_in(rb_n));
  flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_flash_dev_model (.ce_n_in(ce_n_out),
    .oe_n_in(oe_n_out), .we_n_in(we_n_out), .rp_n_in(rp_n), .addr_in(flash_addr), .dq_in(dq_host),
    .dq_oe_in(dq_oe), .dq_out(dq_dev), .ready_busy_n_out(rb_n), .viol_out(viol));

  // ************************************************************
  // Clock, watchdog and shared tasks
  // ************************************************************
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Whole run needs well under 10k cycles
  initial begin
    #200us;
    mismatches++;
    give_verdict();
  end
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : check
  // One APB transfer; an idle edge follows so strobes never toggle twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    // Only the watchdog ends a slave that never answers
    while (pready_out !== 1'b1) begin
      @(posedge clock_in);
    end
    rdv = prdata_out;
    pslverr = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask : apb
  task automatic wait_idle();
    int n;
    n = 0;
    rdv = 32'h1;
    while (rdv[0] !== 1'b0 && n < 300) begin
      apb(1'b0, `FH_REG_STATUS, 32'h0);
      n++;
    end
    check("busy", {31'h0, rdv[0]}, 32'h0);
  endtask : wait_idle
  task automatic flash_op(input flash_host_pkg::op_t o, input logic [20:0] a, input logic [15:0] d);
    apb(1'b1, `FH_REG_ADDR, {11'h0, a});
    apb(1'b1, `FH_REG_WDATA, {16'h0, d});
    apb(1'b1, `FH_REG_CTRL, {29'h0, o});
    wait_idle();
    check("done", {31'h0, rdv[2]}, 32'h1);
    apb(1'b1, `FH_REG_STATUS, 32'h4);
  endtask : flash_op
  task automatic rd_flash(input logic [20:0] a, input logic [15:0] exp, input string what);
    flash_op(flash_host_pkg::OP_READ, a, 16'h0);
    apb(1'b0, `FH_REG_RDATA, 32'h0);
    check(what, rdv, {16'h0, exp});
  endtask : rd_flash

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_boot();
    apb(1'b0, `FH_REG_STATUS, 32'h0);
    check("busy at boot", {31'h0, rdv[0]}, 32'h1);
    wait_idle();
    check("idle pins", {27'h0, ce_n_out, oe_n_out, we_n_out, rp_n, dq_oe}, 32'h1e);
    rd_flash(21'h01234, 16'h1234 ^ 16'h5a5a, "array word");
  endtask : t_boot
  task automatic t_id();
    flash_op(flash_host_pkg::OP_ID_MODE, 21'h0, `FH_CMD_ID_READ);
    rd_flash(21'h000000, MAKER, "maker");
    rd_flash(21'h000001, DEVICE, "device");
    rd_flash(21'h000003, 16'h0000, "perm lock");
    rd_flash(21'h1f8002, 16'h0000, "block lock");
    rd_flash(21'h008001, 16'hffff, "reserved");
    rd_flash(21'h000080, 16'hfffe, "lock word");
  endtask : t_id
  task automatic t_otp();
    flash_op(flash_host_pkg::OP_OTP_PROG, 21'h85, 16'h1234);
    flash_op(flash_host_pkg::OP_OTP_PROG, 21'h81, 16'h0000);
    flash_op(flash_host_pkg::OP_OTP_LOCK, 21'h0, 16'h0);
    flash_op(flash_host_pkg::OP_OTP_PROG, 21'h86, 16'h0000);
    flash_op(flash_host_pkg::OP_OTP_PROG, 21'h80, 16'hffff);
    flash_op(flash_host_pkg::OP_ID_MODE, 21'h0, 16'h0);
    rd_flash(21'h85, 16'h1234, "otp data");
    rd_flash(21'h81, 16'hffff, "factory area");
    rd_flash(21'h80, 16'hfffc, "locked word");
    rd_flash(21'h86, 16'hffff, "locked area");
    flash_op(flash_host_pkg::OP_ARRAY_MODE, 21'h0, 16'h0);
    rd_flash(21'h85, 16'h0085 ^ 16'h5a5a, "back to array");
  endtask : t_otp
  task automatic t_reset_and_busy();
    flash_op(flash_host_pkg::OP_ID_MODE, 21'h0, 16'h0);
    flash_op(flash_host_pkg::OP_RESET, 21'h0, 16'h0);
    rd_flash(21'h0, 16'h5a5a, "after reset");
    flash_op(flash_host_pkg::OP_ID_MODE, 21'h0, 16'h0);
    flash_op(flash_host_pkg::OP_ARRAY_MODE, 21'h0, 16'h0);
    apb(1'b1, `FH_REG_CTRL, {29'h0, flash_host_pkg::OP_READ});
    apb(1'b1, `FH_REG_CTRL, {29'h0, flash_host_pkg::OP_ID_MODE});
    wait_idle();
    apb(1'b1, `FH_REG_STATUS, 32'h4);
    rd_flash(21'h0, 16'h5a5a, "start dropped when busy");
    flash_op(flash_host_pkg::OP_WRITE, 21'h0, `FH_CMD_ID_READ);
    rd_flash(21'h000001, DEVICE, "raw write command");
    flash_op(flash_host_pkg::OP_WRITE, 21'h0, `FH_CMD_READ_ARRAY);
    rd_flash(21'h000001, 16'h0001 ^ 16'h5a5a, "raw array command");
  endtask : t_reset_and_busy
  task automatic t_regs();
    apb(1'b1, `FH_REG_CTRL, 32'h30);
    check("pin levels", {30'h0, byte_n, wp_n}, 32'h1);
    apb(1'b1, `FH_REG_CTRL, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", {31'h0, pslverr}, 32'h1);
    check("unmapped data", rdv, 32'h0);
    apb(1'b0, `FH_REG_STATUS, 32'h0);
    check("ready pin", {31'h0, rdv[1]}, 32'h1);
  endtask : t_regs

  initial begin
    rst_n_in = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (2) @(posedge clock_in);
    check("pin low in reset", {31'h0, rp_n}, 32'h0);
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_boot();
    t_id();
    t_otp();
    t_reset_and_busy();
    t_regs();
    check("far side faults", viol, 32'h0);
    give_verdict();
  end
endmodule : flash_host_tb
